// ### logic/tms_pkg.sv
package tms_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ     = 20_000_000;                  // System clock rate
	localparam int PHASE1_MS  = 100;                         // Analog power-up phase
	localparam int WAKE_MS    = 200;                         // Whole wake-up period
	localparam int PHASE1_CYC = CLK_HZ / 1000 * PHASE1_MS;   // Rounded down
	localparam int WAKE_CYC   = CLK_HZ / 1000 * WAKE_MS;     // Start-up length
	localparam int CONV_CYC   = 2000;                        // One channel conversion
	localparam logic [2:0] HALF_CYC = 3'h4;                  // Half period of the serial clock

	// ==========================================================
	// Serial instructions and command byte
	localparam logic [7:0] INS_READ   = 8'h03;               // Memory read
	localparam logic [7:0] INS_WRITE  = 8'h02;               // Memory write
	localparam logic [7:0] CMD_SLEEP  = 8'h97;               // Sleep command value
	localparam logic [7:0] STAT_INIT  = 8'h80;               // Status while initialising
	localparam logic [7:0] STAT_READY = 8'h40;               // Start clear, done set
	localparam int         START_BIT  = 7;                   // Start flag position
	localparam int         DONE_BIT   = 6;                   // Done flag position
	localparam logic [4:0] NUM_CH     = 5'h14;               // Twenty input channels

	// ==========================================================
	// Device memory map (byte addresses)
	localparam logic [9:0] ADR_CMD      = 10'h000;           // conversion_command_status
	localparam logic [9:0] ADR_RES_LO   = 10'h010;           // Result words
	localparam logic [9:0] ADR_RES_HI   = 10'h05f;
	localparam logic [9:0] ADR_KEY_LO   = 10'h0b0;           // nonvolatile_unlock_key
	localparam logic [9:0] ADR_KEY_HI   = 10'h0b3;
	localparam logic [9:0] ADR_NV_RES   = 10'h0d0;           // nonvolatile_read_outcome
	localparam logic [9:0] ADR_GLOBAL   = 10'h0f0;           // global_setup
	localparam logic [9:0] ADR_MASK_LO  = 10'h0f4;           // multi_channel_select_mask
	localparam logic [9:0] ADR_MASK_HI  = 10'h0f7;
	localparam logic [9:0] ADR_NV_STATE = 10'h0f9;           // nonvolatile_state
	localparam logic [9:0] ADR_MUX_DLY  = 10'h0ff;           // input_switch_settle_delay
	localparam logic [9:0] ADR_ASG_LO   = 10'h200;           // Channel assignment words
	localparam logic [9:0] ADR_ASG_HI   = 10'h24f;
	localparam logic [9:0] ADR_CUST_LO  = 10'h250;           // Custom sensor table
	localparam logic [9:0] ADR_CUST_HI  = 10'h3cf;

	// ==========================================================
	// Controller registers (AHB byte offsets)
	localparam logic [7:0] REG_ADDR  = 8'h00;                // Target address
	localparam logic [7:0] REG_WDATA = 8'h04;                // Bytes to write
	localparam logic [7:0] REG_CTRL  = 8'h08;                // Go / status
	localparam logic [7:0] REG_RDATA = 8'h0c;                // Bytes read
	localparam int CTRL_GO   = 0;                            // Write: start transfer
	localparam int CTRL_WR   = 1;                            // Write: 1 write, 0 read
	localparam int CTRL_LEN  = 2;                            // Bits 3:2 byte count minus one
	localparam int STAT_BUSY = 0;                            // Read: transfer running
	localparam int STAT_INT  = 1;                            // Read: interrupt pin level

	// ==========================================================
	// Types
	typedef logic [4:0] tms_chan_t;
	typedef enum logic [2:0] {ST_WAKE, ST_READY, ST_SCAN, ST_CONV, ST_STORE, ST_SLEEP}
		tms_dev_state_t;
	typedef enum logic [1:0] {PH_INS, PH_AHI, PH_ALO, PH_DAT} tms_spi_phase_t;
	typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_END, HS_GAP} tms_host_state_t;

endpackage

// ### logic/tms_spi_if.sv
// ==========================================================
// Serial link between controller and measurement device
interface tms_spi_if;
	logic cs_n;        // Chip select, active low
	logic sclk;        // Serial clock from controller
	logic mosi;        // Controller to device data
	logic miso_o;      // Device data out
	logic miso_oe_n;   // Device drives miso when low
	logic miso;        // Resolved line, pulled high when undriven
	logic intr;        // Interrupt pin, high when ready

	// Pull-up when nobody drives the data-out line
	assign miso = miso_oe_n ? 1'b1 : miso_o;

	modport dev  (input cs_n, input sclk, input mosi, output miso_o, output miso_oe_n,
		output intr);
	modport host (output cs_n, output sclk, output mosi, input miso, input intr);
endinterface

// ### logic/tms_dev.sv
// Register access over AHB-Lite was chosen for this implementation.
module tms_dev #(
	parameter int PHASE1_CYC = tms_pkg::PHASE1_CYC,   // Status lockout length
	parameter int WAKE_CYC   = tms_pkg::WAKE_CYC      // Start-up length, at least 1024
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	tms_spi_if.dev           spi,
	input  wire logic [31:0] result_in,
	output logic             conv_busy,
	output tms_pkg::tms_chan_t conv_channel,
	output logic [31:0]      conv_cfg,
	output logic             sleeping
);
	import tms_pkg::*;

	// ==========================================================
	// Storage and state
	logic [7:0]      mem [0:1023];   // Byte-addressed map
	tms_dev_state_t  state_q;        // Sequencer state
	logic [21:0]     tmr_q;          // Wake-up and conversion timer
	logic [7:0]      cmd_q;          // Command status byte
	tms_chan_t       chan_q;         // Channel being converted
	logic            multi_q;        // Multiple-channel run
	logic [1:0]      byte_q;         // Result byte being stored
	logic [31:0]     res_q;          // Captured result word
	logic            intr_q;         // Interrupt pin
	logic [2:0]      sclk_q;         // Serial clock sync and edge
	logic [2:0]      cs_q;           // Chip select sync and edge
	logic [1:0]      mosi_q;         // Data-in sync
	logic [2:0]      bit_q;          // Bit within byte
	tms_spi_phase_t  phase_q;        // Transaction phase
	logic [7:0]      instr_q;        // Instruction byte
	logic [7:0]      sh_in_q;        // Receive shifter
	logic [9:0]      addr_q;         // Current byte address
	logic [7:0]      out_q;          // Transmit shifter

	// ==========================================================
	// Decoded events
	logic        sel;                // Chip selected
	logic        rise;               // Serial clock rising
	logic        fall;               // Serial clock falling
	logic        cs_fall;            // Selection starts
	logic [7:0]  rx_byte;            // Byte completed by this bit
	logic        byte_done;          // Last bit of a byte
	logic        spi_wr;             // Data byte written by host
	logic        cmd_wr;             // Write to the command byte
	logic        mem_we;             // Write to the map
	logic [7:0]  rd_val;             // Byte to shift out next
	logic [31:0] mask;               // Multi-run channel mask
	logic [9:0]  res_adr;            // Result byte address
	logic [9:0]  asg_adr;            // Assignment word address

	assign sel       = ~cs_q[1];
	assign rise      = sclk_q[1] & ~sclk_q[2];
	assign fall      = ~sclk_q[1] & sclk_q[2];
	assign cs_fall   = ~cs_q[1] & cs_q[2];
	assign rx_byte   = {sh_in_q[6:0], mosi_q[1]};
	assign byte_done = sel & rise & (bit_q == 3'h7);
	assign spi_wr    = byte_done & (phase_q == PH_DAT) & (instr_q == INS_WRITE);
	assign cmd_wr    = spi_wr & (addr_q == ADR_CMD) & (state_q == ST_READY);
	assign mem_we    = spi_wr & (state_q == ST_READY) & writable(addr_q);
	assign mask      = {mem[ADR_MASK_LO], mem[ADR_MASK_LO + 10'h1], mem[ADR_MASK_LO + 10'h2],
		mem[ADR_MASK_HI]};
	assign res_adr   = ADR_RES_LO + {3'h0, chan_q - 5'h1, 2'h0} + {8'h00, byte_q};
	assign asg_adr   = ADR_ASG_LO + {3'h0, chan_q - 5'h1, 2'h0};

	// Host may write these bytes; results and read-only bytes excluded
	function automatic logic writable(input logic [9:0] a);
		writable = (a >= ADR_KEY_LO && a <= ADR_KEY_HI) || a == ADR_GLOBAL
			|| (a >= ADR_MASK_LO && a <= ADR_MASK_HI) || a == ADR_MUX_DLY
			|| (a >= ADR_ASG_LO && a <= ADR_CUST_HI);
	endfunction

	// Host may read these bytes besides the command byte
	function automatic logic readable(input logic [9:0] a);
		readable = writable(a) || (a >= ADR_RES_LO && a <= ADR_RES_HI)
			|| a == ADR_NV_RES || a == ADR_NV_STATE;
	endfunction

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_q <= 3'h0;
			cs_q   <= 3'h7;
			mosi_q <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], spi.sclk};
			cs_q   <= {cs_q[1:0], spi.cs_n};
			mosi_q <= {mosi_q[0], spi.mosi};
		end
	end

	// ==========================================================
	// Read value for the next outgoing byte
	always_comb begin
		rd_val = 8'h00;                                      // Reserved reads zero
		if (addr_q == ADR_CMD) begin
			if (state_q != ST_WAKE) begin
				rd_val = cmd_q;                              // Pollable in every state after start-up
			end else if (tmr_q >= 22'(PHASE1_CYC)) begin
				rd_val = STAT_INIT;                          // Initialising
			end
		end else if (state_q == ST_READY && readable(addr_q)) begin
			rd_val = mem[addr_q];                            // Locked out otherwise
		end
	end

	// ==========================================================
	// Serial transaction engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_q   <= 3'h0;
			phase_q <= PH_INS;
			instr_q <= 8'h00;
			sh_in_q <= 8'h00;
			addr_q  <= 10'h000;
			out_q   <= 8'h00;
		end else if (!sel) begin
			// Deselect ends the transaction
			bit_q   <= 3'h0;
			phase_q <= PH_INS;
			out_q   <= 8'h00;
		end else begin
			if (rise) begin
				// Sample data in, MSB first
				bit_q   <= bit_q + 3'h1;
				sh_in_q <= rx_byte;
				if (bit_q == 3'h7) begin
					case (phase_q)
						PH_INS: begin
							instr_q <= rx_byte;
							phase_q <= PH_AHI;
						end
						PH_AHI: begin
							addr_q  <= {rx_byte[1:0], 8'h00};      // High byte first
							phase_q <= PH_ALO;
						end
						PH_ALO: begin
							addr_q  <= {addr_q[9:8], rx_byte};
							phase_q <= PH_DAT;
						end
						default: begin
							if (instr_q == INS_WRITE) begin
								addr_q <= addr_q + 10'h1;         // Next byte
							end
						end
					endcase
				end
			end
			if (fall && phase_q == PH_DAT && instr_q == INS_READ) begin
				// Shift data out on the falling edge
				if (bit_q == 3'h0) begin
					out_q  <= rd_val;
					addr_q <= addr_q + 10'h1;
				end else begin
					out_q <= {out_q[6:0], 1'b0};
				end
			end
		end
	end

	assign spi.miso_o    = out_q[7];
	assign spi.miso_oe_n = cs_q[1];

	// ==========================================================
	// Map writes: clear at start-up, result store, host write
	always_ff @(posedge hclk) begin
		if (state_q == ST_WAKE) begin
			mem[tmr_q[9:0]] <= 8'h00;                        // RAM initialise
		end else if (state_q == ST_STORE) begin
			mem[res_adr] <= res_q[31:24];
		end else if (mem_we) begin
			mem[addr_q] <= rx_byte;                          // Reserved writes dropped
		end
	end

	// ==========================================================
	// Conversion sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_WAKE;
			tmr_q   <= 22'h0;
			cmd_q   <= 8'h00;
			chan_q  <= 5'h0;
			multi_q <= 1'b0;
			byte_q  <= 2'h0;
			res_q   <= 32'h0;
		end else begin
			case (state_q)
				ST_WAKE: begin
					tmr_q <= tmr_q + 22'h1;
					if (tmr_q == 22'(WAKE_CYC - 1)) begin
						state_q <= ST_READY;
						cmd_q   <= STAT_READY;
					end
				end
				ST_READY: begin
					if (cmd_wr && rx_byte == CMD_SLEEP) begin
						state_q <= ST_SLEEP;
					end else if (cmd_wr && rx_byte[START_BIT] && rx_byte[4:0] <= NUM_CH) begin
						// Accepted initiate command
						cmd_q   <= rx_byte;
						tmr_q   <= 22'h0;
						multi_q <= (rx_byte[4:0] == 5'h0);
						chan_q  <= (rx_byte[4:0] == 5'h0) ? 5'h1 : rx_byte[4:0];
						state_q <= (rx_byte[4:0] == 5'h0) ? ST_SCAN : ST_CONV;
					end
				end
				ST_SCAN: begin
					// Walk the mask for the next selected channel
					if (chan_q > NUM_CH) begin
						state_q <= ST_READY;
						cmd_q   <= (cmd_q & ~STAT_INIT) | STAT_READY;
					end else if (mask[chan_q - 5'h1]) begin
						state_q <= ST_CONV;
						tmr_q   <= 22'h0;
					end else begin
						chan_q <= chan_q + 5'h1;
					end
				end
				ST_CONV: begin
					tmr_q <= tmr_q + 22'h1;
					if (tmr_q == 22'(CONV_CYC - 1)) begin
						res_q   <= result_in;
						byte_q  <= 2'h0;
						state_q <= ST_STORE;
					end
				end
				ST_STORE: begin
					// Four result bytes, most significant first
					byte_q <= byte_q + 2'h1;
					res_q  <= {res_q[23:0], 8'h00};
					if (byte_q == 2'h3) begin
						if (multi_q) begin
							chan_q  <= chan_q + 5'h1;
							state_q <= ST_SCAN;
						end else begin
							state_q <= ST_READY;
							cmd_q   <= (cmd_q & ~STAT_INIT) | STAT_READY;
						end
					end
				end
				default: begin
					// Sleep until the next selection, then start up again
					if (cs_fall) begin
						state_q <= ST_WAKE;
						tmr_q   <= 22'h0;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Interrupt pin and user-side outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intr_q       <= 1'b0;
			conv_busy    <= 1'b0;
			conv_channel <= 5'h0;
			conv_cfg     <= 32'h0;
			sleeping     <= 1'b0;
		end else begin
			intr_q       <= (state_q == ST_READY);
			conv_busy    <= (state_q == ST_CONV);
			conv_channel <= chan_q;
			conv_cfg     <= {mem[asg_adr], mem[asg_adr + 10'h1], mem[asg_adr + 10'h2],
				mem[asg_adr + 10'h3]};
			sleeping     <= (state_q == ST_SLEEP);
		end
	end

	assign spi.intr = intr_q;

endmodule // tms_dev

// ### logic/tms_host.sv
// ==========================================================
// Controller: AHB-Lite registers in, serial master out
module tms_host (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	tms_spi_if.host          spi
);
	import tms_pkg::*;

	// ==========================================================
	// Registers
	tms_host_state_t st_q;          // Transfer state
	logic            dph_we_q;      // Write data phase pending
	logic [7:0]      dph_adr_q;     // Address of that phase
	logic [9:0]      addr_q;        // Target address
	logic [31:0]     wdata_q;       // Bytes to write
	logic [31:0]     rdata_q;       // Bytes read
	logic [55:0]     tx_q;          // Outgoing bit stream
	logic [5:0]      bits_q;        // Bits left
	logic [2:0]      div_q;         // Half-period counter
	logic            sclk_q;        // Serial clock
	logic            cs_n_q;        // Chip select
	logic [1:0]      miso_q;        // Data-in sync
	logic [1:0]      intr_q;        // Interrupt sync
	logic            go;            // Start request

	assign hreadyout = 1'b1;        // Zero wait states
	assign hresp     = 1'b0;        // Always OKAY
	assign go        = dph_we_q && dph_adr_q == REG_CTRL && hwdata[CTRL_GO] && st_q == HS_IDLE;

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			miso_q <= 2'h0;
			intr_q <= 2'h0;
		end else begin
			miso_q <= {miso_q[0], spi.miso};
			intr_q <= {intr_q[0], spi.intr};
		end
	end

	// ==========================================================
	// Bus slave: address phase capture, read data, write data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_we_q  <= 1'b0;
			dph_adr_q <= 8'h00;
			hrdata    <= 32'h0;
			addr_q    <= 10'h000;
			wdata_q   <= 32'h0;
		end else begin
			if (hready) begin
				dph_we_q  <= hsel & htrans[1] & hwrite;
				dph_adr_q <= haddr[7:0];
				if (hsel && htrans[1] && !hwrite) begin
					// Read data comes from flops in the data phase
					if (haddr[7:0] == REG_ADDR) begin
						hrdata <= {22'h0, addr_q};
					end else if (haddr[7:0] == REG_WDATA) begin
						hrdata <= wdata_q;
					end else if (haddr[7:0] == REG_CTRL) begin
						hrdata <= {30'h0, intr_q[1], st_q != HS_IDLE};
					end else if (haddr[7:0] == REG_RDATA) begin
						hrdata <= rdata_q;
					end else begin
						hrdata <= 32'h0;                         // Unmapped
					end
				end
			end
			if (dph_we_q && dph_adr_q == REG_ADDR) begin
				addr_q <= hwdata[9:0];
			end else if (dph_we_q && dph_adr_q == REG_WDATA) begin
				wdata_q <= hwdata;
			end
		end
	end

	// ==========================================================
	// Serial master, clock idles low, data changes on falling edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q    <= HS_IDLE;
			tx_q    <= 56'h0;
			bits_q  <= 6'h0;
			div_q   <= 3'h0;
			sclk_q  <= 1'b0;
			cs_n_q  <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			case (st_q)
				HS_IDLE: begin
					if (go) begin
						// Instruction, two address bytes, then data
						tx_q    <= {hwdata[CTRL_WR] ? INS_WRITE : INS_READ, 6'h00, addr_q,
							wdata_q << (5'h18 - {hwdata[CTRL_LEN +: 2], 3'h0})};
						bits_q  <= 6'h20 + {1'b0, hwdata[CTRL_LEN +: 2], 3'h0};
						div_q   <= 3'h0;
						cs_n_q  <= 1'b0;
						rdata_q <= 32'h0;
						st_q    <= HS_RUN;
					end
				end
				HS_RUN: begin
					div_q <= div_q + 3'h1;
					if (div_q == HALF_CYC - 3'h1) begin
						div_q  <= 3'h0;
						sclk_q <= ~sclk_q;
						if (sclk_q) begin
							// End of high phase: take a bit, move to the next
							rdata_q <= {rdata_q[30:0], miso_q[1]};
							tx_q    <= {tx_q[54:0], 1'b0};
							bits_q  <= bits_q - 6'h1;
							if (bits_q == 6'h1) begin
								st_q <= HS_END;
							end
						end
					end
				end
				HS_END: begin
					// Hold select a half period past the last edge
					div_q <= div_q + 3'h1;
					if (div_q == HALF_CYC - 3'h1) begin
						div_q  <= 3'h0;
						cs_n_q <= 1'b1;
						st_q   <= HS_GAP;
					end
				end
				default: begin
					// Deselect time before the next transfer
					div_q <= div_q + 3'h1;
					if (div_q == HALF_CYC - 3'h1) begin
						div_q <= 3'h0;
						st_q  <= HS_IDLE;
					end
				end
			endcase
		end
	end

	assign spi.cs_n = cs_n_q;
	assign spi.sclk = sclk_q;
	assign spi.mosi = tx_q[55];

endmodule // tms_host

// ### verification/tms_spi_assertions.sv
module tms_spi_assertions
	import tms_pkg::*;
#(
	parameter int WAKE_CYC = 2000         // Start-up length
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso_oe_n,
	input wire logic intr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        sclk_q;                  // Serial clock one cycle back
	logic [6:0]  bits_q;                  // Rising serial edges in frame
	logic [15:0] up_q;                    // Cycles since reset release
	logic [15:0] low_q;                   // Cycles with interrupt low
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========================================================
	// Helper counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_q <= 1'b0;
			bits_q <= 7'h00;
			up_q   <= 16'h0000;
			low_q  <= 16'h0000;
		end else begin
			sclk_q <= sclk;
			bits_q <= cs_n ? 7'h00 : bits_q + 7'((sclk && !sclk_q) ? 1 : 0);
			up_q   <= (up_q == 16'hffff) ? up_q : up_q + 16'h0001;
			low_q  <= intr ? 16'h0000 : ((low_q == 16'hffff) ? low_q : low_q + 16'h0001);
		end
	end
	sequence s_high4; sclk [*4] ##1 !sclk; endsequence
	// ==========================================================
	// Checks
	AST_SCLK_FRAMED: assert property (sclk |-> !cs_n) else $error("sclk outside frame");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_high4) else $error("sclk high phase");
	AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*4]) else $error("sclk low phase");
	AST_BIT_COUNT: assert property ($rose(cs_n) |-> bits_q >= 7'd32 && bits_q <= 7'd56
		&& bits_q[2:0] == 3'h0) else $error("frame bit count");
	AST_MOSI_HOLD: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi moved while sclk high");
	AST_MISO_DRIVE: assert property ($fell(cs_n) |-> ##[1:3] !miso_oe_n)
		else $error("miso not driven");
	AST_MISO_FREE: assert property ($rose(cs_n) |-> ##[1:3] miso_oe_n)
		else $error("miso not released");
	AST_WAKE_LOW: assert property (up_q < 16'(WAKE_CYC - 2) |-> !intr)
		else $error("interrupt early");
	AST_WAKE_HIGH: assert property (up_q == 16'(WAKE_CYC + 100) |-> intr)
		else $error("interrupt late");
	AST_CONV_LEN: assert property ($rose(intr) |-> low_q >= 16'(CONV_CYC))
		else $error("interrupt low too short");
endmodule // tms_spi_assertions

// ### verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tms_pkg::*;
	localparam int P1 = 600;                                  // Shortened lockout
	localparam int WK = 2000;                                 // Shortened start-up
	localparam logic [9:0]  AD [5] = '{10'h24c, 10'h0f4, 10'h3cc, 10'h060, 10'h05c};
	localparam logic [31:0] WD [5] = '{32'ha5c30f12, 32'h000a0003, 32'h01020304,
		32'hffffffff, 32'h12345678};
	localparam logic [31:0] EX [5] = '{32'ha5c30f12, 32'h000a0003, 32'h01020304,
		32'h0, 32'h0};
	logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hready;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, result_in = 32'h0, conv_cfg;
	logic        hreadyout, hresp, conv_busy, sleeping;
	tms_chan_t   conv_channel;
	int          fails = 0, n_tests = 0, cyc = 0;
	tms_spi_if spi_bus ();
	assign hready = hreadyout;                                // Single slave
	always #25 hclk = ~hclk;
	tms_host tms_host_inst (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp, .spi(spi_bus));
	tms_dev #(.PHASE1_CYC(P1), .WAKE_CYC(WK)) tms_dev_inst (.hclk, .hresetn, .spi(spi_bus),
		.result_in, .conv_busy, .conv_channel, .conv_cfg, .sleeping);
	tms_spi_assertions #(.WAKE_CYC(WK)) tms_spi_assertions_inst (.hclk, .hresetn,
		.cs_n(spi_bus.cs_n), .sclk(spi_bus.sclk), .mosi(spi_bus.mosi),
		.miso_oe_n(spi_bus.miso_oe_n), .intr(spi_bus.intr));
	// ==========================================================
	// Shared tasks
	task automatic final_report;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic spi(logic wr, logic [9:0] a, int n, logic [31:0] wd, output logic [31:0] rd);
		logic [31:0] s;
		ahb(1'b1, REG_ADDR, {22'h0, a}, s);
		ahb(1'b1, REG_WDATA, wd, s);
		ahb(1'b1, REG_CTRL, {28'h0, 2'(n - 1), wr, 1'b1}, s);
		repeat (3) @(posedge hclk);
		do ahb(1'b0, REG_CTRL, 32'h0, s); while (s[STAT_BUSY] !== 1'b0);
		ahb(1'b0, REG_RDATA, 32'h0, rd);
	endtask
	task automatic wait_ready;
		logic [31:0] s;
		do ahb(1'b0, REG_CTRL, 32'h0, s); while (s[STAT_INT] !== 1'b1);
	endtask
	task automatic do_reset;
		hresetn <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_startup;
		logic [31:0] r;
		spi(1'b0, ADR_CMD, 1, 32'h0, r);
		chk("status locked", 32'h0, r);
		chk("bus response", 32'h0, {31'h0, hresp});
		repeat (400) @(posedge hclk);
		spi(1'b0, ADR_CMD, 1, 32'h0, r);
		chk("status init", {24'h0, STAT_INIT}, r);
		wait_ready;
		spi(1'b0, ADR_CMD, 1, 32'h0, r);
		chk("status ready", {24'h0, STAT_READY}, r);
	endtask
	task automatic t_map;
		logic [31:0] r;
		for (int i = 0; i < 5; i++) begin
			spi(1'b1, AD[i], 4, WD[i], r);
			spi(1'b0, AD[i], 4, 32'h0, r);
			chk("map word", EX[i], r);
		end
	endtask
	task automatic t_conv;
		logic [31:0] r;
		result_in <= 32'hc0ffee01;
		spi(1'b1, ADR_CMD, 1, 32'h94, r);
		chk("conv busy", 32'h1, {31'h0, conv_busy});
		chk("conv chan", 32'd20, {27'h0, conv_channel});
		chk("conv cfg", WD[0], conv_cfg);
		spi(1'b1, ADR_ASG_LO, 4, 32'h11111111, r);
		spi(1'b0, ADR_ASG_HI - 10'h3, 4, 32'h0, r);
		chk("locked read", 32'h0, r);
		spi(1'b0, ADR_CMD, 1, 32'h0, r);
		chk("status running", 32'h94, r);
		wait_ready;
		spi(1'b0, ADR_CMD, 1, 32'h0, r);
		chk("status done", 32'h1, {30'h0, r[START_BIT:DONE_BIT]});
		spi(1'b0, ADR_RES_HI - 10'h3, 4, 32'h0, r);
		chk("result ch20", 32'hc0ffee01, r);
		spi(1'b0, ADR_ASG_LO, 4, 32'h0, r);
		chk("locked write", 32'h0, r);
	endtask
	// Multi run over the mask written in t_map: channels 1, 2, 18 and 20
	task automatic t_multi;
		logic [31:0] r;
		result_in <= 32'h5a5a0102;
		spi(1'b1, ADR_CMD, 1, 32'h80, r);
		chk("multi chan", 32'd1, {27'h0, conv_channel});
		wait_ready;
		spi(1'b0, ADR_CMD, 1, 32'h0, r);
		chk("multi done", {24'h0, STAT_READY}, r);
		spi(1'b0, ADR_RES_LO, 4, 32'h0, r);
		chk("multi ch1", 32'h5a5a0102, r);
		spi(1'b0, ADR_RES_LO + 10'h44, 4, 32'h0, r);
		chk("multi ch18", 32'h5a5a0102, r);
		spi(1'b0, ADR_RES_LO + 10'h8, 4, 32'h0, r);
		chk("multi skip ch3", 32'h0, r);
		spi(1'b1, ADR_ASG_LO + 10'h8, 4, 32'h0badcafe, r);
		spi(1'b0, ADR_ASG_LO + 10'h8, 4, 32'h0, r);
		chk("append cfg", 32'h0badcafe, r);
	endtask
	task automatic t_sleep;
		logic [31:0] r;
		spi(1'b1, ADR_CMD, 1, {24'h0, CMD_SLEEP}, r);
		chk("sleeping", 32'h1, {31'h0, sleeping});
		do_reset;
		wait_ready;
		spi(1'b0, ADR_ASG_HI - 10'h3, 4, 32'h0, r);
		chk("cleared word", 32'h0, r);
	endtask
	// ==========================================================
	// Sequence and hang guard
	initial begin
		do_reset;
		t_startup;
		t_map;
		t_conv;
		t_multi;
		t_sleep;
		final_report;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			fails++;
			final_report;
		end
	end
endmodule // testbench
